//--- common/btc_pkg.sv
// Constants, operation codes and carriers for the bit-test and compare unit.
// Assumes a core that decodes the instruction and supplies operand values.
// Function
// RQ1 - Skip next when selected bit is clear
// RQ2 - Skip next when selected bit is set
// RQ3 - Skip ops one word, flags untouched
// RQ4 - Carry form: bit to carry, then set
// RQ5 - Zero form: bit to zero, then set
// RQ6 - Compare base register with 5-bit literal
// RQ7 - Compare base minus source, flags only
// RQ8 - Compare operand with zero, flags only
// RQ9 - Skip costs two or three cycles
package btc_pkg;
	localparam int BTC_DATA_W = 16;
	localparam int BTC_BIT_W = 4;
	localparam int BTC_LIT_W = 5;
	localparam int BTC_NIB_MSB = 3;
	localparam logic [1:0] BTC_SKIP_ONE_WORD = 2'h1;
	localparam logic [1:0] BTC_SKIP_TWO_WORD = 2'h2;
	localparam logic [15:0] BTC_ZERO_WORD = 16'h0000;

	typedef enum logic [2:0] {
		BTC_OP_NONE = 3'h0,
		BTC_OP_SKIP_CLR = 3'h1,
		BTC_OP_SKIP_SET = 3'h2,
		BTC_OP_TSET_C = 3'h3,
		BTC_OP_TSET_Z = 3'h4,
		BTC_OP_CMP_LIT = 3'h5,
		BTC_OP_CMP_REG = 3'h6,
		BTC_OP_CMP_ZERO = 3'h7
	} btc_op_e;

	// Status flags this unit may touch
	typedef struct packed {
		logic carry;
		logic digit_carry_flag;
		logic negative;
		logic signed_range_exceeded_flag;
		logic zero;
	} btc_flags_s;

	// One issued instruction with its operands
	typedef struct packed {
		btc_op_e op;
		logic [15:0] operand_a;
		logic [15:0] operand_b;
		logic [3:0] bit_sel;
		logic [4:0] literal;
	} btc_req_s;
endpackage : btc_pkg

//--- logic/btc_subtract.sv
// Flag-only subtractor shared by every compare form.
// Assumes operands are settled within the same cycle.
`timescale 1ns/100ps
`default_nettype none
module btc_subtract
	import btc_pkg::*;
#(
	parameter int WIDTH = BTC_DATA_W
) (
	input wire logic [WIDTH-1:0] i_minuend, // Left operand
	input wire logic [WIDTH-1:0] i_subtrahend, // Right operand
	output btc_flags_s o_flags // Flags as a subtraction sets them
);
	// Elaboration guard: nibble borrow and sign logic need a byte at least
	if (WIDTH < 8) begin : g_width_check
		$error("btc_subtract needs at least 8 bits");
	end

	wire logic [WIDTH:0] diff;
	wire logic [4:0] low_diff;

	// Carry is the inverted borrow, as in a true subtraction [RQ7]
	assign diff = {1'b0, i_minuend} + {1'b0, ~i_subtrahend} + {{WIDTH{1'b0}}, 1'b1};
	assign low_diff = {1'b0, i_minuend[BTC_NIB_MSB:0]} + {1'b0, ~i_subtrahend[BTC_NIB_MSB:0]}
		+ 5'h01;
	assign o_flags.carry = diff[WIDTH];
	assign o_flags.digit_carry_flag = low_diff[4];
	assign o_flags.negative = diff[WIDTH-1];
	assign o_flags.signed_range_exceeded_flag = (i_minuend[WIDTH-1] != i_subtrahend[WIDTH-1])
		&& (diff[WIDTH-1] != i_minuend[WIDTH-1]);
	assign o_flags.zero = (diff[WIDTH-1:0] == '0);
endmodule : btc_subtract
`default_nettype wire

//--- logic/btc_unit.sv
// Execution unit for bit-test skips, bit-test-then-set and compares.
// Assumes the core holds i_req steady while o_busy is high and
// tells whether the instruction after a skip is one or two words.
`timescale 1ns/100ps
`default_nettype none
module btc_unit
	import btc_pkg::*;
#(
	parameter int WIDTH = BTC_DATA_W
) (
	input wire logic i_core_clk, // Core clock
	input wire logic i_sys_rst, // Async reset, high
	input wire logic i_valid, // Instruction issued this cycle
	input wire btc_req_s i_req, // Operation and operands
	input wire logic i_next_two_word, // Following instruction is two words
	input wire btc_flags_s i_flags, // Current status flags
	output btc_flags_s o_flags, // Updated status flags
	output logic o_flags_we, // Flags write strobe
	output logic [WIDTH-1:0] o_wb_data, // Value written back to source
	output logic o_wb_we, // Write-back strobe
	output logic o_skip, // Skip the next instruction
	output logic o_skip_two, // Skipped instruction is two words
	output logic o_busy, // Extra skip cycles in progress
	output logic o_done // Instruction retired
);
	// Elaboration guard: masks and literal padding assume 16-bit words
	if (WIDTH != BTC_DATA_W) begin : g_width_check
		$error("btc_unit operates on 16-bit words only");
	end

	// Gray along the usual path: run, one skip cycle, maybe a second
	typedef enum logic [1:0] {
		BTC_ST_RUN = 2'b00,
		BTC_ST_SKIP1 = 2'b01,
		BTC_ST_SKIP2 = 2'b11
	} btc_state_e;

	btc_state_e state;
	btc_state_e next_state;

	// Single-bit mask from the 4-bit selector
	function automatic logic [15:0] btc_mask(input logic [3:0] sel);
		btc_mask = 16'h0001 << sel;
	endfunction : btc_mask

	wire logic [15:0] sel_mask;
	wire logic sel_bit;
	wire logic op_skip_clr;
	wire logic op_skip_set;
	wire logic op_tset_c;
	wire logic op_tset_z;
	wire logic op_cmp_lit;
	wire logic op_cmp_zero;
	wire logic is_skip_op;
	wire logic take_skip;
	wire logic [15:0] cmp_right;
	wire logic [15:0] cmp_left;
	wire btc_flags_s sub_flags;
	btc_flags_s next_flags;
	logic next_flags_we;

	// One-hot view of the operation code, so each use reads plainly
	assign op_skip_clr = (i_req.op == BTC_OP_SKIP_CLR);
	assign op_skip_set = (i_req.op == BTC_OP_SKIP_SET);
	assign op_tset_c = (i_req.op == BTC_OP_TSET_C);
	assign op_tset_z = (i_req.op == BTC_OP_TSET_Z);
	assign op_cmp_lit = (i_req.op == BTC_OP_CMP_LIT);
	assign op_cmp_zero = (i_req.op == BTC_OP_CMP_ZERO);

	// Bit selection shared by skip and test-then-set ops
	assign sel_mask = btc_mask(i_req.bit_sel);
	assign sel_bit = |(i_req.operand_a & sel_mask);
	assign is_skip_op = op_skip_clr || op_skip_set;
	assign take_skip = (op_skip_clr && !sel_bit) // [RQ1]
		|| (op_skip_set && sel_bit); // [RQ2]

	// Compare operand steering; literal is zero-extended, never signed [RQ6]
	assign cmp_left = i_req.operand_a;
	assign cmp_right = op_cmp_lit ? {{(BTC_DATA_W - BTC_LIT_W){1'b0}}, i_req.literal} :
		op_cmp_zero ? BTC_ZERO_WORD : i_req.operand_b; // [RQ7] [RQ8]

	btc_subtract #(
		.WIDTH(BTC_DATA_W)
	) u_sub (
		.i_minuend(cmp_left),
		.i_subtrahend(cmp_right),
		.o_flags(sub_flags)
	);

	// Flag merge: only the documented flags move, others pass through
	always_comb begin
		next_flags = i_flags;
		next_flags_we = 1'b0;
		case (i_req.op)
			BTC_OP_TSET_C: begin
				next_flags.carry = sel_bit; // [RQ4]
				next_flags_we = 1'b1;
			end
			BTC_OP_TSET_Z: begin
				next_flags.zero = !sel_bit; // [RQ5]
				next_flags_we = 1'b1;
			end
			BTC_OP_CMP_LIT, BTC_OP_CMP_REG, BTC_OP_CMP_ZERO: begin
				next_flags = sub_flags; // [RQ6] [RQ7] [RQ8]
				next_flags_we = 1'b1;
			end
			default: begin
				next_flags = i_flags; // Skip ops leave flags alone [RQ3]
			end
		endcase
	end

	// Skip sequencing: one cycle, plus one or two for the skipped word(s)
	always_comb begin
		case (state)
			BTC_ST_RUN: begin
				if (i_valid && take_skip) begin
					next_state = BTC_ST_SKIP1; // [RQ3] [RQ9]
				end else begin
					next_state = BTC_ST_RUN;
				end
			end
			BTC_ST_SKIP1: begin
				next_state = o_skip_two ? BTC_ST_SKIP2 : BTC_ST_RUN; // [RQ9]
			end
			BTC_ST_SKIP2: begin
				next_state = BTC_ST_RUN;
			end
			default: begin
				next_state = BTC_ST_RUN;
			end
		endcase
	end

	// Issue handshake: a request is only taken while no skip is in flight
	wire logic accept;
	wire logic is_tset;
	wire logic next_busy;
	wire logic next_flags_strobe;
	wire logic next_wb_strobe;
	wire logic [15:0] next_wb_data;
	wire logic next_skip;
	wire logic next_skip_two;
	wire logic skip_tail_done;
	wire logic next_done;

	// Refused requests get no indication; the core must watch o_busy
	assign accept = i_valid && (state == BTC_ST_RUN);
	assign next_busy = (next_state != BTC_ST_RUN); // [RQ9]

	// Both bit-test-then-set forms write the operand back
	assign is_tset = op_tset_c || op_tset_z;

	// Strobes fire only for a taken request, never for a refused one
	assign next_flags_strobe = accept && next_flags_we; // [RQ3]
	assign next_wb_strobe = accept && is_tset; // [RQ4] [RQ5]

	// Old bit feeds the flag while the written word has it set
	assign next_wb_data = i_req.operand_a | sel_mask; // [RQ4] [RQ5]

	// Skip report; the size of the skipped word is kept with it
	assign next_skip = accept && is_skip_op && take_skip; // [RQ1] [RQ2]
	assign next_skip_two = take_skip && i_next_two_word; // [RQ9]

	// Retire at once for a plain op, or on the last skip cycle
	assign skip_tail_done = ((state == BTC_ST_SKIP1) && !o_skip_two)
		|| (state == BTC_ST_SKIP2); // [RQ9]
	assign next_done = (accept && !take_skip && (i_req.op != BTC_OP_NONE))
		|| skip_tail_done; // [RQ3]

	// Sequencer state and busy level
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state <= BTC_ST_RUN;
			o_busy <= 1'b0;
		end else begin
			state <= next_state;
			o_busy <= next_busy;
		end
	end

	// Flags held between instructions, so a stale request cannot move them
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_flags <= '0;
			o_flags_we <= 1'b0;
		end else begin
			o_flags_we <= next_flags_strobe;
			if (accept) begin
				o_flags <= next_flags;
			end
		end
	end

	// Write-back port, same holding rule as the flags
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_wb_data <= '0;
			o_wb_we <= 1'b0;
		end else begin
			o_wb_we <= next_wb_strobe;
			if (accept) begin
				o_wb_data <= next_wb_data;
			end
		end
	end

	// Skip report and retirement; skip size latched at issue
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_skip <= 1'b0;
			o_skip_two <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_skip <= next_skip;
			o_done <= next_done;
			if (accept) begin
				o_skip_two <= next_skip_two;
			end
		end
	end
endmodule : btc_unit
`default_nettype wire

//--- tb/btc_unit_chk.sv
// Port checks for the bit-test and compare unit.
// Assumes one core clock and the async high reset.
`timescale 1ns/100ps
`default_nettype none
module btc_unit_chk
	import btc_pkg::*;
#(
	parameter int WIDTH = BTC_DATA_W
) (
	input wire logic i_core_clk, // Clock
	input wire logic i_sys_rst, // Reset
	input wire logic i_valid, // Issue
	input wire btc_req_s i_req, // Request
	input wire logic i_next_two_word, // Two-word next
	input wire btc_flags_s i_flags, // Flags in
	input wire btc_flags_s o_flags, // Flags out
	input wire logic o_flags_we, // Flags strobe
	input wire logic [WIDTH-1:0] o_wb_data, // Write-back
	input wire logic o_wb_we, // Write-back strobe
	input wire logic o_skip, // Skip
	input wire logic o_skip_two, // Two-word skip
	input wire logic o_busy, // Busy
	input wire logic o_done // Done
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	// Accepted request and its tested bit; busy refusals are left out
	wire logic tk = i_valid && !o_busy;
	wire logic bt = i_req.operand_a[i_req.bit_sel];
	sequence s_one; o_skip && !o_skip_two; endsequence
	sequence s_two; o_skip && o_skip_two; endsequence
	property p_clr; tk && i_req.op == BTC_OP_SKIP_CLR |=> o_skip == !$past(bt); endproperty
	property p_set; tk && i_req.op == BTC_OP_SKIP_SET |=> o_skip == $past(bt); endproperty
	property p_keep; tk && i_req.op inside {BTC_OP_SKIP_CLR, BTC_OP_SKIP_SET}
		|=> !o_flags_we && !o_wb_we && o_flags == $past(i_flags); endproperty
	property p_tc; tk && i_req.op == BTC_OP_TSET_C
		|=> o_wb_we && o_flags.carry == $past(bt); endproperty
	property p_tz; tk && i_req.op == BTC_OP_TSET_Z
		|=> o_flags_we && o_flags.zero != $past(bt); endproperty
	property p_lit; tk && i_req.op == BTC_OP_CMP_LIT && i_req.operand_a[15:5] != 11'h000
		|=> o_flags_we && o_flags.carry && !o_flags.zero; endproperty
	property p_reg; tk && i_req.op == BTC_OP_CMP_REG && i_req.operand_a == i_req.operand_b
		|=> o_flags.zero && o_flags.carry && !o_wb_we; endproperty
	property p_cz; tk && i_req.op == BTC_OP_CMP_ZERO |=> o_flags_we && o_flags.carry
		&& o_flags.digit_carry_flag && !o_flags.signed_range_exceeded_flag; endproperty
	property p_cyc; s_one |-> o_busy ##1 o_done && !o_busy; endproperty
	property p_cyc2; s_two |-> o_busy ##1 o_busy && !o_done ##1 o_done && !o_busy; endproperty
	property p_wbset; tk && i_req.op inside {BTC_OP_TSET_C, BTC_OP_TSET_Z} |=> o_wb_we
		&& o_wb_data == ($past(i_req.operand_a) | (16'h0001 << $past(i_req.bit_sel))); endproperty
	property p_two; tk && i_req.op inside {BTC_OP_SKIP_CLR, BTC_OP_SKIP_SET}
		|=> o_skip_two == (o_skip && $past(i_next_two_word)); endproperty
	a_clr: assert property (p_clr) else $error("clear skip wrong");
	a_set: assert property (p_set) else $error("set skip wrong");
	a_keep: assert property (p_keep) else $error("skip touched state");
	a_tc: assert property (p_tc) else $error("carry form wrong");
	a_tz: assert property (p_tz) else $error("zero form wrong");
	a_lit: assert property (p_lit) else $error("literal compare wrong");
	a_reg: assert property (p_reg) else $error("register compare wrong");
	a_cz: assert property (p_cz) else $error("zero compare wrong");
	a_cyc: assert property (p_cyc) else $error("one-word skip timing");
	a_cyc2: assert property (p_cyc2) else $error("two-word skip timing");
	a_wbset: assert property (p_wbset) else $error("write-back word wrong");
	a_two: assert property (p_two) else $error("skip size wrong");
endmodule : btc_unit_chk
bind btc_unit btc_unit_chk #(.WIDTH(WIDTH)) i_btc_unit_chk (.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_req(i_req), .i_next_two_word(i_next_two_word),
	.i_flags(i_flags), .o_flags(o_flags), .o_flags_we(o_flags_we), .o_wb_data(o_wb_data),
	.o_wb_we(o_wb_we), .o_skip(o_skip), .o_skip_two(o_skip_two), .o_busy(o_busy),
	.o_done(o_done));
`default_nettype wire

//--- tb/btc_unit_tb_top.sv
// Self-checking bench for the bit-test and compare unit.
// Assumes inputs change on the falling edge only.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module btc_unit_tb_top
	import btc_pkg::*;
;
	logic i_core_clk = 0, i_sys_rst = 1, i_valid = 0, i_next_two_word = 0;
	btc_req_s i_req = '0;
	btc_flags_s i_flags = 5'h00, o_flags;
	logic o_flags_we, o_wb_we, o_skip, o_skip_two, o_busy, o_done;
	logic [15:0] o_wb_data;
	int miscompares = 0, num_checks = 0, cyc = 0;
	btc_unit #(.WIDTH(BTC_DATA_W)) i_btc_unit (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_valid(i_valid), .i_req(i_req), .i_next_two_word(i_next_two_word),
		.i_flags(i_flags), .o_flags(o_flags), .o_flags_we(o_flags_we), .o_wb_data(o_wb_data),
		.o_wb_we(o_wb_we), .o_skip(o_skip), .o_skip_two(o_skip_two), .o_busy(o_busy),
		.o_done(o_done));
	// Subtraction flags; carry means no borrow
	function automatic btc_flags_s sub_flags(input logic [15:0] a, b);
		logic [16:0] d;
		logic [4:0] h;
		d = {1'b0, a} - {1'b0, b};
		h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
		return '{~d[16], ~h[4], d[15], (a[15] ^ b[15]) & (a[15] ^ d[15]), d[15:0] == 16'h0000};
	endfunction : sub_flags
	// Leaves valid high so callers may issue back to back
	task automatic issue(input btc_op_e op, input logic [15:0] a, b, input logic [3:0] bn,
		input logic [4:0] lit, input logic two);
		i_req = '{op, a, b, bn, lit};
		i_next_two_word = two;
		i_valid = 1'b1;
		@(negedge i_core_clk);
	endtask : issue
	task automatic wait_done(input int n);
		int k;
		k = 1;
		while (o_done !== 1'b1 && k < 8) begin
			@(negedge i_core_clk);
			k++;
		end
		`CHK(k, n)
	endtask : wait_done
	task automatic test_skips;
		logic [15:0] a;
		logic sk;
		for (int i = 0; i < 8; i++) begin
			a = i[1] ? 16'h0001 << (i * 2 + 1) : ~(16'h0001 << (i * 2 + 1));
			sk = i[2] ? i[1] : !i[1];
			issue(btc_op_e'(i[2] ? BTC_OP_SKIP_SET : BTC_OP_SKIP_CLR), a, 16'h0000,
				4'(i * 2 + 1), 5'h00, i[0]);
			i_valid = 1'b0;
			`CHK(o_skip, sk)
			`CHK(o_flags_we | o_wb_we, 1'b0)
			`CHK(o_skip_two, sk & i[0])
			wait_done(sk ? 2 + i[0] : 1);
			@(negedge i_core_clk); // Valid rests low for an edge before the next issue
		end
		$display("test_skips ended");
	endtask : test_skips
	task automatic test_tsets;
		logic [15:0] a;
		btc_flags_s f;
		i_flags = 5'h15;
		for (int i = 0; i < 8; i++) begin
			a = i[1] ? 16'h8001 : 16'h7ffe;
			f = i_flags;
			if (i[2]) f.zero = !i[1];
			else f.carry = i[1];
			issue(btc_op_e'(i[2] ? BTC_OP_TSET_Z : BTC_OP_TSET_C), a, 16'h0000,
				i[0] ? 4'hf : 4'h0, 5'h00, 1'b0);
			`CHK(o_flags, f)
			`CHK(o_wb_data, a | (i[0] ? 16'h8000 : 16'h0001))
			`CHK({o_wb_we, o_flags_we, o_skip, o_done}, 4'hd)
		end
		i_valid = 1'b0;
		@(negedge i_core_clk);
		$display("test_tsets ended");
	endtask : test_tsets
	task automatic test_cmps;
		logic [15:0] ta [5] = '{16'h0000, 16'h8000, 16'h7fff, 16'h0010, 16'h0005};
		logic [15:0] tb [5] = '{16'h0001, 16'h0001, 16'hffff, 16'h0001, 16'h0005};
		logic [15:0] a, b, bx;
		btc_op_e op;
		for (int j = 0; j < 15; j++) begin
			a = ta[j % 5];
			b = tb[j % 5];
			bx = (j < 5) ? {11'h000, b[4:0]} : (j < 10) ? b : 16'h0000;
			op = btc_op_e'((j < 5) ? BTC_OP_CMP_LIT : (j < 10) ? BTC_OP_CMP_REG : BTC_OP_CMP_ZERO);
			issue(op, a, (j < 5) ? ~b : b, 4'h0, b[4:0], 1'b0);
			`CHK(o_flags, sub_flags(a, bx))
			`CHK({o_flags_we, o_wb_we, o_skip, o_done}, 4'h9)
		end
		i_valid = 1'b0;
		@(negedge i_core_clk);
		$display("test_cmps ended");
	endtask : test_cmps
	// Idle op, then a request offered while a two-word skip is busy
	task automatic test_none;
		issue(BTC_OP_NONE, 16'hffff, 16'hffff, 4'h0, 5'h1f, 1'b0);
		`CHK({o_flags_we, o_wb_we, o_skip, o_busy, o_done}, 5'h00)
		issue(BTC_OP_SKIP_CLR, 16'h0000, 16'h0000, 4'h3, 5'h00, 1'b1);
		`CHK({o_skip, o_skip_two, o_busy}, 3'h7)
		issue(BTC_OP_CMP_REG, 16'h0001, 16'h0001, 4'h0, 5'h00, 1'b0);
		i_valid = 1'b0;
		`CHK({o_flags_we, o_busy, o_done}, 3'h2)
		@(negedge i_core_clk);
		`CHK({o_flags_we, o_busy, o_done}, 3'h1)
		$display("test_none ended");
	endtask : test_none
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict
	// Free-running clock, 100 ns period
	initial forever #50 i_core_clk = ~i_core_clk;
	// Hang guard, far above the roughly 70 cycles needed
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			miscompares++;
			print_verdict();
		end
	end
	// Main sequence
	initial begin
		repeat (16) @(negedge i_core_clk);
		i_sys_rst = 1'b0;
		@(negedge i_core_clk);
		test_skips();
		test_tsets();
		test_cmps();
		test_none();
		print_verdict();
	end
endmodule : btc_unit_tb_top
`default_nettype wire
